/* File: status_led_flasher.sv */
// status lamps, fault flash code player and safety outputs with apb registers
//
// Our own choices: the APB interface to the registers and the address map.
`timescale 1ns/10ps
module status_led_flasher
    import status_led_pkg::*;
#(
    parameter int unsigned SHORT_ON = SHORT_ON_CYC,
    parameter int unsigned SHORT_OFF = SHORT_OFF_CYC,
    parameter int unsigned LONG_ON = LONG_ON_CYC,
    parameter int unsigned LONG_OFF = LONG_OFF_CYC,
    parameter int unsigned HDR_PAUSE = HDR_PAUSE_CYC,
    parameter int unsigned DIGIT_GAP = DIGIT_GAP_CYC,
    parameter int unsigned PARTIAL_HALF = PARTIAL_HALF_CYC
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic ready_in,
    input wire logic in_range,
    input wire logic chan1_in,
    input wire logic chan2_in,
    input wire logic fault_in,
    input wire logic [3:0] code_d0,
    input wire logic [3:0] code_d1,
    input wire logic [3:0] code_d2,
    input wire logic [1:0] code_len,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    output logic led_green,
    output logic led_red,
    output logic led_target,
    output logic led_input,
    output logic safe_out1,
    output logic safe_out2
);

    typedef struct packed {
        flash_state_type state;
        logic [TIMER_W-1:0] timer;
        logic [1:0] hdr_cnt;
        logic [4:0] flash_cnt;
        logic [1:0] dig_idx;
        logic fault_lat;
        logic internal;
        logic [3:0] d0;
        logic [3:0] d1;
        logic [3:0] d2;
        logic [1:0] len;
        logic both_prev;
        logic partial;
        logic led_green;
        logic led_red;
        logic led_target;
        logic led_input;
        logic safe1;
        logic safe2;
        logic [EV_W-1:0] irq_stat;
        logic [EV_W-1:0] irq_mask;
        logic ctrl_sel;
        logic irq;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } state_type;

    state_type st_ff;
    state_type nxt_st;
    logic blink;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [4:0] flashes_of(input logic [3:0] d);
        flashes_of = (d == 4'h0) ? ZERO_FLASHES : {1'h0, d};
    endfunction : flashes_of

    function automatic logic is_wiring(input logic [3:0] a, input logic [3:0] b,
                                       input logic [3:0] c, input logic [1:0] n);
        is_wiring = ((n == 2'h3) && (a == 4'h1) && (b == 4'h4) && (c == 4'h1)) ||
                    ((n == 2'h2) && (a == 4'h1) && (b == 4'hc)) ||
                    ((n == 2'h1) && ((a == 4'he) || (a == 4'hf)));
    endfunction : is_wiring

    half_period_blinker #(
        .HALF_CYC(PARTIAL_HALF)
    ) u_blink (
        .clk_sys(clk_sys),
        .rst(rst),
        .run(st_ff.partial),
        .blink(blink)
    );

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        logic both;
        logic one;
        logic done;
        logic lit;
        logic acc;
        logic [1:0] len_in;
        logic [3:0] cur;
        logic [EV_W-1:0] ev;
        logic [EV_W-1:0] clr;
        both = chan1_in & chan2_in;
        one = chan1_in ^ chan2_in;
        done = (st_ff.timer == '0);
        lit = (st_ff.state == FL_HDR_ON) || (st_ff.state == FL_DIG_ON);
        acc = psel & penable & st_ff.pready;
        len_in = (code_len == 2'h0) ? 2'h1 : code_len;
        ev = '0;
        clr = '0;
        case (st_ff.dig_idx)
            2'h0: cur = st_ff.d0;
            2'h1: cur = st_ff.d1;
            default: cur = st_ff.d2;
        endcase
        nxt_st = st_ff;
        nxt_st.pready = 1'h0;
        nxt_st.pslverr = 1'h0;
        nxt_st.timer = done ? '0 : st_ff.timer - TIMER_W'(1);

        // fault capture and code player; nothing but reset clears the latch
        if (!st_ff.fault_lat && fault_in) begin
            nxt_st.fault_lat = 1'h1;
            ev[EV_FAULT_BIT] = 1'h1;
            nxt_st.d0 = code_d0;
            nxt_st.d1 = code_d1;
            nxt_st.d2 = code_d2;
            nxt_st.len = len_in;
            nxt_st.internal = ~is_wiring(code_d0, code_d1, code_d2, len_in);
            nxt_st.state = FL_HDR_ON;
            nxt_st.timer = TIMER_W'(SHORT_ON - 1);
            nxt_st.hdr_cnt = 2'h0;
        end else if (st_ff.fault_lat) begin
            case (st_ff.state)
                FL_HDR_ON: begin
                    if (done) begin
                        nxt_st.state = FL_HDR_OFF;
                        nxt_st.timer = TIMER_W'(SHORT_OFF - 1);
                    end
                end
                FL_HDR_OFF: begin
                    if (done && st_ff.hdr_cnt == HDR_LAST) begin
                        nxt_st.state = FL_PAUSE;
                        nxt_st.timer = TIMER_W'(HDR_PAUSE - 1);
                        nxt_st.dig_idx = 2'h0;
                    end else if (done) begin
                        nxt_st.state = FL_HDR_ON;
                        nxt_st.timer = TIMER_W'(SHORT_ON - 1);
                        nxt_st.hdr_cnt = st_ff.hdr_cnt + 2'h1;
                    end
                end
                FL_PAUSE: begin
                    if (done) begin
                        nxt_st.state = FL_DIG_ON;
                        nxt_st.timer = TIMER_W'(LONG_ON - 1);
                        nxt_st.flash_cnt = 5'h0;
                    end
                end
                FL_DIG_ON: begin
                    if (done) begin
                        nxt_st.state = FL_DIG_OFF;
                        nxt_st.timer = TIMER_W'(LONG_OFF - 1);
                    end
                end
                FL_DIG_OFF: begin
                    if (done && (st_ff.flash_cnt + 5'h1) == flashes_of(cur)) begin
                        nxt_st.state = FL_GAP;
                        nxt_st.timer = TIMER_W'(DIGIT_GAP - 1);
                    end else if (done) begin
                        nxt_st.state = FL_DIG_ON;
                        nxt_st.timer = TIMER_W'(LONG_ON - 1);
                        nxt_st.flash_cnt = st_ff.flash_cnt + 5'h1;
                    end
                end
                FL_GAP: begin
                    if (done && st_ff.dig_idx == (st_ff.len - 2'h1)) begin
                        nxt_st.state = FL_HDR_ON;
                        nxt_st.timer = TIMER_W'(SHORT_ON - 1);
                        nxt_st.hdr_cnt = 2'h0;
                    end else if (done) begin
                        nxt_st.state = FL_DIG_ON;
                        nxt_st.timer = TIMER_W'(LONG_ON - 1);
                        nxt_st.flash_cnt = 5'h0;
                        nxt_st.dig_idx = st_ff.dig_idx + 2'h1;
                    end
                end
                default: begin
                    nxt_st.state = FL_HDR_ON;
                    nxt_st.timer = TIMER_W'(SHORT_ON - 1);
                    nxt_st.hdr_cnt = 2'h0;
                end
            endcase
        end

        // partial operation: one channel dropped out of the both-high state
        if (!chan1_in && !chan2_in) begin
            nxt_st.partial = 1'h0;
        end else if (both) begin
            nxt_st.partial = 1'h0;
        end else if (st_ff.both_prev && one) begin
            nxt_st.partial = 1'h1;
            ev[EV_PARTIAL_BIT] = ~st_ff.partial;
        end
        nxt_st.both_prev = both;

        // lamps and outputs
        nxt_st.led_green = ready_in & ~st_ff.fault_lat & ~fault_in;
        nxt_st.led_red = st_ff.fault_lat | fault_in;
        if (st_ff.fault_lat && !st_ff.ctrl_sel) begin
            nxt_st.led_target = lit;
        end else begin
            nxt_st.led_target = in_range;
        end
        if (st_ff.fault_lat && st_ff.ctrl_sel) begin
            nxt_st.led_input = lit;
        end else if (both) begin
            nxt_st.led_input = 1'h1;
        end else begin
            nxt_st.led_input = st_ff.partial & blink;
        end
        // a fault forces the safe low state even with the actuator present
        nxt_st.safe1 = in_range & ~st_ff.fault_lat & ~fault_in;
        nxt_st.safe2 = in_range & ~st_ff.fault_lat & ~fault_in;

        // apb access: pready answers one cycle after setup, no wait states
        if (acc && pwrite) begin
            case (paddr)
                IRQ_STATUS_OFS: clr = pwdata[EV_W-1:0];
                IRQ_MASK_OFS: nxt_st.irq_mask = pwdata[EV_W-1:0];
                CTRL_OFS: nxt_st.ctrl_sel = pwdata[CTRL_SEL_BIT];
                STATE_OFS: nxt_st.ctrl_sel = st_ff.ctrl_sel;
                default: nxt_st.ctrl_sel = st_ff.ctrl_sel;
            endcase
        end
        // a new event outranks a clear in the same cycle
        nxt_st.irq_stat = (st_ff.irq_stat & ~clr) | ev;
        nxt_st.irq = |(nxt_st.irq_stat & nxt_st.irq_mask);
        if (psel && !penable && !st_ff.pready) begin
            nxt_st.pready = 1'h1;
            nxt_st.prdata = 32'h0;
            case (paddr)
                IRQ_STATUS_OFS: nxt_st.prdata[EV_W-1:0] = st_ff.irq_stat;
                IRQ_MASK_OFS: nxt_st.prdata[EV_W-1:0] = st_ff.irq_mask;
                CTRL_OFS: nxt_st.prdata[CTRL_SEL_BIT] = st_ff.ctrl_sel;
                STATE_OFS: begin
                    nxt_st.prdata[ST_FAULT_BIT] = st_ff.fault_lat;
                    nxt_st.prdata[ST_INTERNAL_BIT] = st_ff.internal;
                    nxt_st.prdata[ST_PARTIAL_BIT] = st_ff.partial;
                    nxt_st.prdata[ST_RANGE_BIT] = in_range;
                    nxt_st.prdata[ST_FSM_LSB +: 3] = st_ff.state;
                    nxt_st.prdata[ST_D0_LSB +: 4] = st_ff.d0;
                    nxt_st.prdata[ST_D1_LSB +: 4] = st_ff.d1;
                    nxt_st.prdata[ST_D2_LSB +: 4] = st_ff.d2;
                    nxt_st.prdata[ST_LEN_LSB +: 2] = st_ff.len;
                end
                default: nxt_st.pslverr = 1'h1;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // state register; reset is the only way out of a fault
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign prdata = st_ff.prdata;
    assign pready = st_ff.pready;
    assign pslverr = st_ff.pslverr;
    assign irq = st_ff.irq;
    assign led_green = st_ff.led_green;
    assign led_red = st_ff.led_red;
    assign led_target = st_ff.led_target;
    assign led_input = st_ff.led_input;
    assign safe_out1 = st_ff.safe1;
    assign safe_out2 = st_ff.safe2;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    sequence seq_hdr_end;
        st_ff.state == FL_HDR_OFF && st_ff.timer == '0 && st_ff.hdr_cnt == HDR_LAST;
    endsequence

    sequence seq_code_end;
        st_ff.state == FL_GAP && st_ff.timer == '0 && st_ff.dig_idx == st_ff.len - 2'h1;
    endsequence

    a_green_ready: assert property ((ready_in && !st_ff.fault_lat && !fault_in) |=> led_green)
        else $error("green lamp off while ready");
    a_target_range: assert property ((!st_ff.fault_lat && in_range) |=> led_target)
        else $error("target lamp off with actuator in range");
    a_input_both: assert property ((!st_ff.fault_lat && chan1_in && chan2_in) |=> led_input)
        else $error("input lamp off with both channels high");
    a_partial_hold: assert property ((st_ff.partial && (chan1_in ^ chan2_in)) |=> st_ff.partial)
        else $error("partial indication dropped early");
    a_red_fault: assert property (st_ff.fault_lat |=> led_red && !led_green)
        else $error("fault latched but lamp not red");
    a_header_pause: assert property (seq_hdr_end |=> st_ff.state == FL_PAUSE)
        else $error("header not followed by pause");
    a_digit_long: assert property ($rose(st_ff.state == FL_DIG_ON) |->
        st_ff.timer == TIMER_W'(LONG_ON - 1))
        else $error("digit flash length wrong");
    a_digit_count: assert property ((st_ff.state == FL_DIG_OFF && st_ff.timer == '0 &&
        st_ff.flash_cnt + 5'h1 == flashes_of(st_ff.dig_idx == 2'h0 ? st_ff.d0 :
        st_ff.dig_idx == 2'h1 ? st_ff.d1 : st_ff.d2)) |=> st_ff.state == FL_GAP)
        else $error("digit flash count wrong");
    a_code_repeat: assert property (seq_code_end |=> st_ff.state == FL_HDR_ON && st_ff.hdr_cnt == 2'h0)
        else $error("code did not restart with header");
    a_fault_sticky: assert property (st_ff.fault_lat |=> st_ff.fault_lat)
        else $error("fault latch released without reset");
    a_safe_pair: assert property ((safe_out1 == safe_out2) and (st_ff.fault_lat |=> !safe_out1))
        else $error("safety outputs disagree or high in fault");
    a_gap_length: assert property ($rose(st_ff.state == FL_GAP) |->
        st_ff.timer == TIMER_W'(DIGIT_GAP - 1))
        else $error("digit gap length wrong");

endmodule : status_led_flasher

/* File: status_led_pkg.sv */
// constants, register map and state encodings of the status lamp block
package status_led_pkg;

    // ----------------------------------------------------------------
    // clock and timing
    // ----------------------------------------------------------------
    localparam int unsigned CLK_HZ = 40_000_000;
    localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
    localparam int unsigned SHORT_ON_MS = 200;
    localparam int unsigned SHORT_OFF_MS = 200;
    localparam int unsigned LONG_ON_MS = 500;
    localparam int unsigned LONG_OFF_MS = 500;
    localparam int unsigned HDR_PAUSE_MS = 2000;
    localparam int unsigned DIGIT_GAP_MS = 2000;
    localparam int unsigned PARTIAL_HALF_MS = 250;
    localparam int unsigned SHORT_ON_CYC = SHORT_ON_MS * CYC_PER_MS;
    localparam int unsigned SHORT_OFF_CYC = SHORT_OFF_MS * CYC_PER_MS;
    localparam int unsigned LONG_ON_CYC = LONG_ON_MS * CYC_PER_MS;
    localparam int unsigned LONG_OFF_CYC = LONG_OFF_MS * CYC_PER_MS;
    localparam int unsigned HDR_PAUSE_CYC = HDR_PAUSE_MS * CYC_PER_MS;
    localparam int unsigned DIGIT_GAP_CYC = DIGIT_GAP_MS * CYC_PER_MS;
    localparam int unsigned PARTIAL_HALF_CYC = PARTIAL_HALF_MS * CYC_PER_MS;
    localparam int unsigned TIMER_W = 27;

    // ----------------------------------------------------------------
    // flash code shape
    // ----------------------------------------------------------------
    localparam logic [1:0] HDR_LAST = 2'h2;
    localparam logic [4:0] ZERO_FLASHES = 5'h10;

    // ----------------------------------------------------------------
    // register map
    // ----------------------------------------------------------------
    localparam logic [11:0] IRQ_STATUS_OFS = 12'h000;
    localparam logic [11:0] IRQ_MASK_OFS = 12'h004;
    localparam logic [11:0] CTRL_OFS = 12'h008;
    localparam logic [11:0] STATE_OFS = 12'h00c;
    localparam int unsigned EV_FAULT_BIT = 0;
    localparam int unsigned EV_PARTIAL_BIT = 1;
    localparam int unsigned EV_W = 2;
    localparam int unsigned CTRL_SEL_BIT = 0;
    localparam int unsigned ST_FAULT_BIT = 0;
    localparam int unsigned ST_INTERNAL_BIT = 1;
    localparam int unsigned ST_PARTIAL_BIT = 2;
    localparam int unsigned ST_RANGE_BIT = 3;
    localparam int unsigned ST_FSM_LSB = 4;
    localparam int unsigned ST_D0_LSB = 8;
    localparam int unsigned ST_D1_LSB = 12;
    localparam int unsigned ST_D2_LSB = 16;
    localparam int unsigned ST_LEN_LSB = 20;

    // ----------------------------------------------------------------
    // flash sequencer states
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        FL_IDLE = 3'b000,
        FL_HDR_ON = 3'b001,
        FL_HDR_OFF = 3'b010,
        FL_PAUSE = 3'b011,
        FL_DIG_ON = 3'b100,
        FL_DIG_OFF = 3'b101,
        FL_GAP = 3'b110
    } flash_state_type;

endpackage : status_led_pkg

/* File: half_period_blinker.sv */
// square wave that runs only while run is high, used for the partial operation lamp
`timescale 1ns/10ps
module half_period_blinker
    import status_led_pkg::*;
#(
    parameter int unsigned HALF_CYC = PARTIAL_HALF_CYC
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic run,
    output logic blink
);

    typedef struct packed {
        logic [TIMER_W-1:0] cnt;
        logic blink;
    } blink_state_type;

    blink_state_type st_ff;
    blink_state_type nxt_st;

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        nxt_st = st_ff;
        if (!run) begin
            // restart lit so the first half period is always visible
            nxt_st.cnt = TIMER_W'(HALF_CYC - 1);
            nxt_st.blink = 1'h1;
        end else if (st_ff.cnt == '0) begin
            nxt_st.cnt = TIMER_W'(HALF_CYC - 1);
            nxt_st.blink = ~st_ff.blink;
        end else begin
            nxt_st.cnt = st_ff.cnt - TIMER_W'(1);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign blink = st_ff.blink;

endmodule : half_period_blinker

/* File: status_led_eval_model.sv */
// partner model: two-channel evaluation device reading the safety outputs
`timescale 1ns/10ps
module status_led_eval_model #(
    parameter int unsigned SKEW = 2
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic safe_out1,
    input wire logic safe_out2,
    output logic enabled,
    output logic disc_ff
);
    int unsigned cnt_ff;
    // a short skew between channels is tolerated, a lasting one is latched
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            cnt_ff <= 0;
            disc_ff <= 1'b0;
        end else begin
            cnt_ff <= (safe_out1 !== safe_out2) ? cnt_ff + 1 : 0;
            if (cnt_ff > SKEW) begin
                disc_ff <= 1'b1;
            end
        end
    end
    assign enabled = safe_out1 & safe_out2;
endmodule : status_led_eval_model

/* File: tb_status_led_flasher.sv */
// self-checking testbench of the status lamp flasher
`timescale 1ns/10ps
module tb_status_led_flasher;
    import status_led_pkg::*;
    typedef struct {logic [31:0] d; logic [31:0] m; logic e;} note_type;
    logic clk_sys = 0, rst = 1, ready_in = 0, in_range = 0, chan1_in = 0, chan2_in = 0;
    logic fault_in = 0, psel = 0, penable = 0, pwrite = 0, sel = 0, prev;
    logic [3:0] code_d0 = 0, code_d1 = 0, code_d2 = 0;
    logic [1:0] code_len = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rnd;
    logic pready, pslverr, irq, led_green, led_red, led_target, led_input;
    logic safe_out1, safe_out2, enabled, disc_ff;
    logic [11:0] codes[5] = '{12'h141, 12'h0c1, 12'h00e, 12'h00f, 12'h002};
    int lens[5] = '{3, 2, 1, 1, 2};
    int seed = 32'h34c66cb1;
    int num_errors = 0, checks = 0, cyc = 0, tg;
    note_type notes[$];
    note_type nt;

    // distinct lengths apart from T_HALF equal to T_LOFF, so that a code timer loaded with the wrong length shows up
    localparam int T_SON = 4, T_SOFF = 3, T_LON = 6, T_LOFF = 5;
    localparam int T_PAUSE = 12, T_GAP = 14, T_HALF = 5;

    status_led_flasher #(.SHORT_ON(T_SON), .SHORT_OFF(T_SOFF), .LONG_ON(T_LON),
        .LONG_OFF(T_LOFF), .HDR_PAUSE(T_PAUSE), .DIGIT_GAP(T_GAP),
        .PARTIAL_HALF(T_HALF)) status_led_flasher_i (
        .clk_sys(clk_sys), .rst(rst), .ready_in(ready_in), .in_range(in_range),
        .chan1_in(chan1_in), .chan2_in(chan2_in), .fault_in(fault_in),
        .code_d0(code_d0), .code_d1(code_d1), .code_d2(code_d2), .code_len(code_len),
        .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
        .led_green(led_green), .led_red(led_red), .led_target(led_target),
        .led_input(led_input), .safe_out1(safe_out1), .safe_out2(safe_out2));
    status_led_eval_model status_led_eval_model_i (.clk_sys(clk_sys), .rst(rst),
        .safe_out1(safe_out1), .safe_out2(safe_out2), .enabled(enabled), .disc_ff(disc_ff));

    always #12.5 clk_sys = ~clk_sys;

    // ----------------------------------------------------------------
    // checking and bus tasks
    // ----------------------------------------------------------------
    task chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: %s got %h exp %h", $time, msg, got, exp);
        end
    endtask : chk

    task results;
        $display("errors %0d checks %0d", num_errors, checks);
        if (num_errors == 0 && checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : results

    task tk(input int n);
        repeat (n) @(posedge clk_sys);
    endtask : tk

    // expected answer is queued before the request goes out
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
             input logic [31:0] ed, input logic [31:0] m, input logic e);
        note_type n;
        n.d = ed;
        n.m = m;
        n.e = e;
        notes.push_back(n);
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task wr(input logic [11:0] a, input logic [31:0] d, input logic e);
        apb(1'b1, a, d, 32'h0, 32'h0, e);
    endtask : wr

    task rd(input logic [11:0] a, input logic [31:0] ed, input logic [31:0] m, input logic e);
        apb(1'b0, a, 32'h0, ed, m, e);
    endtask : rd

    always @(posedge clk_sys) begin
        cyc++;
        if (cyc > 20000) begin
            num_errors++;
            results();
        end else if (psel && penable && pready === 1'b1) begin
            nt = notes.pop_front();
            chk(prdata & nt.m, nt.d, "prdata");
            chk(pslverr, nt.e, "pslverr");
        end
    end

    // ----------------------------------------------------------------
    // flash code measurement
    // ----------------------------------------------------------------
    function automatic logic lamp();
        return sel ? led_input : led_target;
    endfunction : lamp

    task pulse(output int on, output int off);
        on = 0;
        off = 0;
        while (lamp() !== 1'b1 && off < 100) begin
            @(posedge clk_sys);
            off++;
        end
        while (lamp() === 1'b1 && on < 100) begin
            @(posedge clk_sys);
            on++;
        end
    endtask : pulse

    // two full passes, so the replay after the last digit is seen too
    task play(input logic [11:0] c, input int len);
        int on, off, n;
        for (int r = 0; r < 2; r++) begin
            for (int h = 0; h < 3; h++) begin
                pulse(on, off);
                chk(on, T_SON, "short flash");
                if (h > 0) chk(off, T_SOFF, "short dark");
                else if (r > 0) chk(off, T_LOFF + T_GAP, "replay gap");
            end
            for (int i = 0; i < len; i++) begin
                n = (c[4*i +: 4] == 4'h0) ? 16 : c[4*i +: 4];
                for (int k = 0; k < n; k++) begin
                    pulse(on, off);
                    chk(on, T_LON, "long flash");
                    if (k > 0) chk(off, T_LOFF, "flash spacing");
                    else chk(off, (i == 0) ? T_SOFF + T_PAUSE : T_LOFF + T_GAP,
                             "digit pause");
                end
            end
        end
    endtask : play

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        tk(12);
        rst <= 1'b0;
        ready_in <= 1'b1;
        in_range <= 1'b1;
        rd(IRQ_STATUS_OFS, 32'h0, 32'hffffffff, 1'b0);
        rd(IRQ_MASK_OFS, 32'h0, 32'hffffffff, 1'b0);
        rd(CTRL_OFS, 32'h0, 32'hffffffff, 1'b0);
        rnd = $random(seed);
        wr(IRQ_MASK_OFS, rnd, 1'b0);
        rd(IRQ_MASK_OFS, rnd & 32'h3, 32'hffffffff, 1'b0);
        wr(12'h010, rnd, 1'b1);
        rd(12'h010, 32'h0, 32'hffffffff, 1'b1);
        chk({led_green, led_red}, 2'b10, "power lamp");
        chk({led_target, safe_out1, safe_out2, enabled}, 4'hf, "in range");
        in_range <= 1'b0;
        tk(3);
        chk({led_target, safe_out1, safe_out2, enabled}, 4'h0, "out of range");
        wr(IRQ_MASK_OFS, 32'h2, 1'b0);
        wr(IRQ_STATUS_OFS, 32'h3, 1'b0);
        chan1_in <= 1'b1;
        chan2_in <= 1'b1;
        tk(3);
        chk({led_input, irq}, 2'b10, "both high");
        chan2_in <= 1'b0;
        tg = 0;
        prev = led_input;
        repeat (22) begin
            @(posedge clk_sys);
            tg += (led_input !== prev);
            prev = led_input;
        end
        chk(tg >= 3, 1, "partial blink");
        chk(irq, 1, "partial event");
        wr(IRQ_STATUS_OFS, 32'h2, 1'b0);
        chan1_in <= 1'b0;
        tk(3);
        chk({led_input, irq}, 2'b00, "both low");
        for (int t = 0; t < 5; t++) begin
            rst <= 1'b1;
            // the target lamp must be dark before it carries the code, else the first flash merges
            in_range <= (t != 0);
            tk(2);
            rst <= 1'b0;
            rnd = $random(seed);
            code_d0 <= codes[t][3:0];
            code_d1 <= lens[t] > 1 ? codes[t][7:4] : rnd[3:0];
            code_d2 <= lens[t] > 2 ? codes[t][11:8] : rnd[7:4];
            code_len <= lens[t][1:0];
            sel = (t == 4);
            wr(CTRL_OFS, {31'h0, sel}, 1'b0);
            fault_in <= 1'b1;
            @(posedge clk_sys);
            fault_in <= 1'b0;
            if (t == 0 || t == 4) play(codes[t], lens[t]);
            else tk(5);
            chk({led_red, led_green}, 2'b10, "fault latched");
            chk({safe_out1, safe_out2}, 2'b00, "safe in fault");
            rd(STATE_OFS, {10'h0, lens[t][1:0], codes[t], 6'h0, t == 4, 1'b1},
               {10'h0, 2'h3, lens[t] > 2 ? 4'hf : 4'h0, lens[t] > 1 ? 4'hf : 4'h0,
               4'hf, 8'h3}, 1'b0);
            if (t == 0) begin
                chk(irq, 0, "masked fault");
                wr(IRQ_MASK_OFS, 32'h1, 1'b0);
                tk(2);
                chk(irq, 1, "fault event");
                wr(IRQ_STATUS_OFS, 32'h1, 1'b0);
                tk(2);
                chk(irq, 0, "event cleared");
            end
        end
        chk(disc_ff, 0, "channel skew");
        results();
    end
endmodule : tb_status_led_flasher
